// file: dmatsc_top.sv
// dma service sequencer with ram port time-out detection
// assumes port grants/time-outs are on clk_i; sync events are single-cycle pulses
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`include "dmatsc_defs.svh"
module dmatsc_top #(
   parameter int NCH = 6
) (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // wishbone slave
   input  wire logic               cyc_i,
   input  wire logic               stb_i,
   input  wire logic               we_i,
   input  wire logic [7:0]         adr_i,
   input  wire logic [3:0]         sel_i,
   input  wire logic [31:0]        dat_i,
   output logic      [31:0]        dat_o,
   output logic                    ack_o,
   // channel requests and port selection
   input  wire logic [NCH-1:0]     sync_evt_i,
   input  wire logic [NCH-1:0]     src_port_peri_i,
   input  wire logic [NCH-1:0]     src_ram_dual_i,
   input  wire logic [NCH-1:0]     dst_ram_dual_i,
   input  wire logic [NCH-1:0]     last_elem_i,
   // memory side
   input  wire logic               cpu_sram_req_i,
   input  wire logic [1:0]         cpu_dram_cnt_i,
   input  wire logic               ext_grant_i,
   input  wire logic               ext_timeout_i,
   input  wire logic               peri_grant_i,
   input  wire logic               peri_timeout_i,
   input  wire logic               host_req_i,
   input  wire logic               idle_req_i,
   input  wire logic               serial_req_i,
   input  wire logic               breakpoint_i,
   output dmatsc_pkg::dmatsc_acc_t acc_o,
   output logic [2:0]              acc_ch_o,
   output logic                    host_slot_o,
   output logic                    idle_o,
   output logic                    bus_err_irq_o
);
   // acc_ch_o is three bits wide, so eight channels at most
   if (NCH < 1 || NCH > 8) begin : g_bad_nch
      $error("NCH must be 1..8");
   end

   logic [NCH-1:0] ch_en_r;
   logic [NCH-1:0] ch_fs_r;
   logic [NCH-1:0] ch_sync_r;
   logic [NCH-1:0] ch_toie_r;
   logic [NCH-1:0] ch_to_r;
   logic [NCH-1:0] pend_r;
   logic [NCH-1:0] mid_r;
   logic [2:0]     gcr_r;
   logic           dual_ram_timeout_enable_r;
   logic           single_ram_timeout_enable_r;
   logic           compat_r;
   logic [2:0]     cur_r;
   logic [7:0]     dcnt_r;
   logic [7:0]     scnt_r;
   logic           idle_r;
   logic           host_turn_r;
   dmatsc_pkg::dmatsc_state_t st_r;

   // bus decode
   logic       wb_req;
   logic [3:0] ch_idx;
   logic [2:0] ch_sel;
   logic [3:0] ch_ofs;
   logic       ch_hit;
   logic       csr_rd;
   assign wb_req = cyc_i & stb_i & ~ack_o;
   // full index compared, so high addresses do not alias onto low channels
   assign ch_idx = 4'((adr_i - `DMATSC_CH_BASE) >> 4);
   assign ch_sel = ch_idx[2:0];
   assign ch_ofs = adr_i[3:0];
   assign ch_hit = (adr_i >= `DMATSC_CH_BASE) && (32'(ch_idx) < NCH);
   assign csr_rd = wb_req & ~we_i & ch_hit & (ch_ofs == `DMATSC_CSR_OFS);

   always_ff @(posedge clk_i) begin
      if (rst_i) ack_o <= 1'b0;
      else ack_o <= wb_req;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0;
      end else if (wb_req && !we_i) begin
         dat_o <= 32'h0;
         if (adr_i == `DMATSC_GCR_ADDR) dat_o <= {28'h0, 1'b1, gcr_r};
         else if (adr_i == `DMATSC_GSCR_ADDR) dat_o <= {31'h0, compat_r};
         else if (adr_i == `DMATSC_GTCR_ADDR) dat_o <= {30'h0, single_ram_timeout_enable_r, dual_ram_timeout_enable_r};
         else if (ch_hit) begin
            case (ch_ofs)
               `DMATSC_CCR_OFS:  dat_o <= {24'h0, ch_en_r[ch_sel], 1'b0,
                                           ch_fs_r[ch_sel], 4'h0, ch_sync_r[ch_sel]};
               `DMATSC_CICR_OFS: dat_o <= {31'h0, ch_toie_r[ch_sel]};
               `DMATSC_CSR_OFS:  dat_o <= {31'h0, ch_to_r[ch_sel]};
               default:          dat_o <= 32'h0;
            endcase
         end
      end
   end

   // global registers, reset values per layout
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gcr_r    <= 3'h0;
         dual_ram_timeout_enable_r   <= 1'b0;
         single_ram_timeout_enable_r   <= 1'b0;
         compat_r <= 1'b0;
      end else if (wb_req && we_i && sel_i[0]) begin
         if (adr_i == `DMATSC_GCR_ADDR) gcr_r <= dat_i[2:0];
         if (adr_i == `DMATSC_GSCR_ADDR) compat_r <= dat_i[0];
         if (adr_i == `DMATSC_GTCR_ADDR) begin
            dual_ram_timeout_enable_r <= dat_i[`DMATSC_GTCR_DUAL_RAM_TIMEOUT_ENABLE];
            single_ram_timeout_enable_r <= dat_i[`DMATSC_GTCR_SINGLE_RAM_TIMEOUT_ENABLE];
         end
      end
   end

   // sequencer signals
   logic       excl;
   logic       free;
   logic       susp;
   logic       cur_peri;
   logic       cur_dual;
   logic       on_ram;
   logic       ram_stall;
   logic       grant;
   logic       timeout;
   logic       dram_to;
   logic       sram_to;
   logic       acc_req;
   logic       acc_done;
   logic [2:0] nxt_ch;
   logic       nxt_ok;
   logic [NCH-1:0] elig;
   assign excl = gcr_r[`DMATSC_GCR_EXCL];
   assign free = gcr_r[`DMATSC_GCR_FREE];
   assign susp = breakpoint_i & ~free;
   assign cur_peri = (st_r == dmatsc_pkg::DMATSC_READ) ? src_port_peri_i[cur_r] : 1'b0;
   assign cur_dual = (st_r == dmatsc_pkg::DMATSC_READ) ? src_ram_dual_i[cur_r]
                                                      : dst_ram_dual_i[cur_r];
   assign on_ram = ~cur_peri;
   // sram single access: any cpu access wins; dram only beyond two
   assign ram_stall = cur_dual ? (cpu_dram_cnt_i > 2'd2) : cpu_sram_req_i;
   assign acc_req = (st_r != dmatsc_pkg::DMATSC_IDLE) && !susp
                    && !(on_ram && excl);
   assign grant = cur_peri ? peri_grant_i : ~ram_stall;
   assign acc_done = acc_req & grant;
   assign dram_to = dual_ram_timeout_enable_r && on_ram && cur_dual && (dcnt_r == `DMATSC_RAM_TIMEOUT);
   assign sram_to = single_ram_timeout_enable_r && on_ram && !cur_dual && (scnt_r == `DMATSC_RAM_TIMEOUT);
   assign timeout = (st_r != dmatsc_pkg::DMATSC_IDLE)
                    && (dram_to || sram_to || ext_timeout_i || peri_timeout_i);

   // while idle is pending only channels part way through a block may start
   assign elig = (idle_req_i && !serial_req_i) ? (pend_r & mid_r) : pend_r;

   // round robin pick from the channel after the current one
   always_comb begin
      nxt_ch = cur_r;
      nxt_ok = 1'b0;
      for (int k = NCH; k >= 1; k--) begin
         if (elig[(32'(cur_r) + k) % NCH]) begin
            nxt_ch = 3'((32'(cur_r) + k) % NCH);
            nxt_ok = 1'b1;
         end
      end
   end

   // counters reset on service or new request
   always_ff @(posedge clk_i) begin
      if (rst_i || acc_done || !acc_req) begin
         dcnt_r <= 8'h0;
         scnt_r <= 8'h0;
      end else begin
         if (cur_dual && dcnt_r != `DMATSC_RAM_TIMEOUT) dcnt_r <= dcnt_r + 8'h1;
         if (!cur_dual && scnt_r != `DMATSC_RAM_TIMEOUT) scnt_r <= scnt_r + 8'h1;
      end
   end

   // element: read into buffer, then write out
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r        <= dmatsc_pkg::DMATSC_IDLE;
         cur_r       <= 3'h0;
         host_turn_r <= 1'b0;
      end else begin
         case (st_r)
            dmatsc_pkg::DMATSC_IDLE: begin
               // host gets a slot like a channel when sharing
               if (host_req_i && !excl && !host_turn_r) host_turn_r <= 1'b1;
               else begin
                  host_turn_r <= 1'b0;
                  if (nxt_ok && (!idle_r || serial_req_i) && !susp) begin
                     cur_r <= nxt_ch;
                     st_r  <= dmatsc_pkg::DMATSC_READ;
                  end
               end
            end
            dmatsc_pkg::DMATSC_READ: begin
               if (timeout) st_r <= dmatsc_pkg::DMATSC_IDLE;
               else if (acc_done) st_r <= dmatsc_pkg::DMATSC_WRITE;
            end
            dmatsc_pkg::DMATSC_WRITE: begin
               if (timeout || acc_done) st_r <= dmatsc_pkg::DMATSC_IDLE;
            end
            default: st_r <= dmatsc_pkg::DMATSC_IDLE;
         endcase
      end
   end

   // idle entry waits for block, frame or element boundary
   logic elem_end;
   logic bound;
   assign elem_end = (st_r == dmatsc_pkg::DMATSC_WRITE) && acc_done;
   assign bound = !ch_sync_r[cur_r] ? last_elem_i[cur_r]
                                    : (ch_fs_r[cur_r] ? last_elem_i[cur_r] : 1'b1);
   always_ff @(posedge clk_i) begin
      if (rst_i) idle_r <= 1'b0;
      else if (!idle_req_i) idle_r <= 1'b0;
      // halt only between elements, once no block or frame is left open
      else if (st_r == dmatsc_pkg::DMATSC_IDLE && !serial_req_i && !(|mid_r)) idle_r <= 1'b1;
   end

   // per-channel control and status
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         logic wsel;
         logic hit_to;
         assign wsel = wb_req & we_i & sel_i[0] & ch_hit & (32'(ch_sel) == g);
         assign hit_to = timeout && (32'(cur_r) == g);
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               ch_en_r[g]   <= 1'b0;
               ch_fs_r[g]   <= 1'b0;
               ch_sync_r[g] <= 1'b0;
               ch_toie_r[g] <= 1'b0;
            end else begin
               if (hit_to) ch_en_r[g] <= 1'b0;
               else if (wsel && ch_ofs == `DMATSC_CCR_OFS) begin
                  ch_en_r[g]   <= dat_i[`DMATSC_CCR_EN];
                  ch_fs_r[g]   <= dat_i[`DMATSC_CCR_FS];
                  ch_sync_r[g] <= dat_i[0];
               end
               if (wsel && ch_ofs == `DMATSC_CICR_OFS) ch_toie_r[g] <= dat_i[`DMATSC_CICR_TOIE];
            end
         end
         // set wins over read-clear
         always_ff @(posedge clk_i) begin
            if (rst_i) ch_to_r[g] <= 1'b0;
            else if (hit_to && ch_toie_r[g]) ch_to_r[g] <= 1'b1;
            else if (csr_rd && 32'(ch_sel) == g) ch_to_r[g] <= 1'b0;
         end
         // unsynchronized channels always pending; synchronized wait for event
         always_ff @(posedge clk_i) begin
            if (rst_i) pend_r[g] <= 1'b0;
            else if (!ch_en_r[g] || hit_to) pend_r[g] <= 1'b0;
            else if (!ch_sync_r[g] || sync_evt_i[g]) pend_r[g] <= 1'b1;
            else if (elem_end && 32'(cur_r) == g) pend_r[g] <= 1'b0;
         end
         // block or frame still open on this channel
         always_ff @(posedge clk_i) begin
            if (rst_i || !ch_en_r[g]) mid_r[g] <= 1'b0;
            else if (elem_end && 32'(cur_r) == g) mid_r[g] <= !bound;
         end
      end
   endgenerate

   assign acc_o.req  = acc_req;
   assign acc_o.port = cur_peri ? 2'(dmatsc_pkg::DMATSC_PORT_PERI)
                     : (cur_dual ? 2'(dmatsc_pkg::DMATSC_PORT_DRAM)
                                 : 2'(dmatsc_pkg::DMATSC_PORT_SRAM));
   assign acc_o.wr   = (st_r == dmatsc_pkg::DMATSC_WRITE);
   assign acc_ch_o   = cur_r;
   assign host_slot_o = host_turn_r | excl;
   assign idle_o     = idle_r;
   assign bus_err_irq_o = |(ch_to_r & ch_toie_r);

   a_ram_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
      (dram_to && st_r == dmatsc_pkg::DMATSC_READ) |=> st_r == dmatsc_pkg::DMATSC_IDLE)
      else $error("dual ram time-out did not end access");
   a_to_disable: assert property (@(posedge clk_i) disable iff (rst_i)
      timeout |=> !ch_en_r[$past(cur_r)])
      else $error("channel stayed enabled after time-out");
   a_cpu_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_req && !cur_peri && !cur_dual && cpu_sram_req_i) |-> !acc_done)
      else $error("dma served against cpu on single ram");
   a_excl_block: assert property (@(posedge clk_i) disable iff (rst_i)
      (excl && !cur_peri) |-> !acc_req)
      else $error("ram access under exclusive host");
   a_brk_susp: assert property (@(posedge clk_i) disable iff (rst_i)
      (breakpoint_i && !free) |-> !acc_req)
      else $error("access during breakpoint");
   a_csr_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (csr_rd && !timeout) |=> ch_to_r[$past(ch_sel)] == 1'b0)
      else $error("status not cleared by read");
   a_irq_status: assert property (@(posedge clk_i) disable iff (rst_i)
      (timeout && ch_toie_r[cur_r]) |=> bus_err_irq_o)
      else $error("bus error not raised");
   a_elem_order: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_r == dmatsc_pkg::DMATSC_READ && acc_done && !timeout)
      |=> st_r == dmatsc_pkg::DMATSC_WRITE)
      else $error("write did not follow read");

   // element steps, time-out paths, dual ram stall, host slot and idle handling
   sequence s_elem_read;
      st_r == dmatsc_pkg::DMATSC_READ && acc_done && !timeout;
   endsequence
   sequence s_elem_write;
      st_r == dmatsc_pkg::DMATSC_WRITE && acc_o.wr;
   endsequence
   a_read_write: assert property (@(posedge clk_i) disable iff (rst_i)
      s_elem_read |=> s_elem_write)
      else $error("read not followed by a write access");
   a_sram_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
      (sram_to && st_r != dmatsc_pkg::DMATSC_IDLE) |=> st_r == dmatsc_pkg::DMATSC_IDLE)
      else $error("single ram time-out did not end access");
   a_peri_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
      (peri_timeout_i && st_r != dmatsc_pkg::DMATSC_IDLE) |=> st_r == dmatsc_pkg::DMATSC_IDLE)
      else $error("peripheral time-out did not end access");
   a_to_unpend: assert property (@(posedge clk_i) disable iff (rst_i)
      timeout |=> !pend_r[$past(cur_r)])
      else $error("channel still pending after time-out");
   a_dram_free: assert property (@(posedge clk_i) disable iff (rst_i)
      (acc_req && !cur_peri && cur_dual && cpu_dram_cnt_i <= 2'd2) |-> acc_done)
      else $error("dual ram access stalled by two cpu accesses");
   a_cnt_restart: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_done |=> (dcnt_r == 8'h0 && scnt_r == 8'h0))
      else $error("time-out counter kept counting after service");
   a_host_slot: assert property (@(posedge clk_i) disable iff (rst_i)
      (host_req_i && !excl && !host_turn_r && st_r == dmatsc_pkg::DMATSC_IDLE) |=> host_slot_o)
      else $error("sharing host got no slot");
   a_idle_mid: assert property (@(posedge clk_i) disable iff (rst_i)
      (!idle_r && |mid_r) |=> !idle_r)
      else $error("idle entered inside a block");
   a_idle_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      (idle_r && !serial_req_i && st_r == dmatsc_pkg::DMATSC_IDLE)
      |=> st_r == dmatsc_pkg::DMATSC_IDLE)
      else $error("element started while idle");
   a_idle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (idle_r && idle_req_i) |=> idle_r)
      else $error("idle left while still requested");
endmodule

// file: dmatsc_defs.svh
// constants for the dma time-out and service control block
// assumes a classic wishbone slave with 32-bit data, word aligned registers
`ifndef DMATSC_DEFS_SVH
`define DMATSC_DEFS_SVH
`define DMATSC_GCR_ADDR     8'h00
`define DMATSC_GSCR_ADDR    8'h04
`define DMATSC_GTCR_ADDR    8'h08
`define DMATSC_CH_BASE      8'h20
`define DMATSC_CH_STRIDE    8'h10
`define DMATSC_CCR_OFS      4'h0
`define DMATSC_CICR_OFS     4'h4
`define DMATSC_CSR_OFS      4'h8
`define DMATSC_GCR_RST      4'h8
`define DMATSC_GCR_PRIO     0
`define DMATSC_GCR_EXCL     1
`define DMATSC_GCR_FREE     2
`define DMATSC_GTCR_DUAL_RAM_TIMEOUT_ENABLE    0
`define DMATSC_GTCR_SINGLE_RAM_TIMEOUT_ENABLE    1
`define DMATSC_CCR_EN       7
`define DMATSC_CCR_FS       5
`define DMATSC_CICR_TOIE    0
`define DMATSC_CSR_TO       0
`define DMATSC_RAM_TIMEOUT  8'hff
`define DMATSC_PERI_MIN_NS  20
`define DMATSC_PERI_MIN_CYC ((`DMATSC_PERI_MIN_NS + 3) / 4)
`endif

// file: dmatsc_pkg.sv
// types for the dma time-out and service control block
// assumes dmatsc_defs.svh for all numeric constants
package dmatsc_pkg;
   typedef enum logic [1:0] {
      DMATSC_PORT_DRAM,
      DMATSC_PORT_SRAM,
      DMATSC_PORT_EXT,
      DMATSC_PORT_PERI
   } dmatsc_port_t;
   typedef enum logic [1:0] {
      DMATSC_IDLE,
      DMATSC_READ,
      DMATSC_WRITE
   } dmatsc_state_t;
   typedef struct packed {
      logic       req;
      logic [1:0] port;
      logic       wr;
   } dmatsc_acc_t;
endpackage

// file: dmatsc_far_model.sv
// far-side model: peripheral bus controller and external memory interface
// assumes acc_i is the sequencer's access struct, sampled on clk_i
`timescale 1ns/100ps
module dmatsc_far_model #(
   parameter int PERI_LAT = 5,
   parameter int EXT_LIM  = 8
) (
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // access from the sequencer, fault control
   input  wire dmatsc_pkg::dmatsc_acc_t acc_i,
   input  wire logic                    hang_i,
   // answers
   output logic                         peri_grant_o,
   output logic                         peri_timeout_o,
   output logic                         ext_grant_o,
   output logic                         ext_timeout_o
);
   logic [7:0] peri_cnt_r;
   logic [7:0] ext_cnt_r;
   logic       peri_act;
   logic       ext_act;
   logic       ext_ready;
   assign peri_act = acc_i.req && acc_i.port == dmatsc_pkg::DMATSC_PORT_PERI && !peri_grant_o;
   assign ext_act = acc_i.req && acc_i.port == dmatsc_pkg::DMATSC_PORT_EXT && !ext_grant_o;
   // a hung far side keeps the ready line low
   assign ext_ready = !hang_i;
   always_ff @(posedge clk_i) begin
      peri_cnt_r <= (rst_i || !peri_act || peri_timeout_o) ? 8'h00 : peri_cnt_r + 8'h01;
   end
   // no answer before the minimum access time; hung access times out at 127
   always_ff @(posedge clk_i) begin
      peri_grant_o   <= !rst_i && peri_act && !hang_i && peri_cnt_r == 8'(PERI_LAT - 2);
      peri_timeout_o <= !rst_i && peri_act && hang_i && peri_cnt_r == 8'h7d;
   end
   // only ready-low cycles count; one memory space modelled
   always_ff @(posedge clk_i) begin
      ext_cnt_r     <= (rst_i || !ext_act || ext_timeout_o) ? 8'h00 : ext_cnt_r + 8'(!ext_ready);
      ext_grant_o   <= !rst_i && ext_act && ext_ready;
      ext_timeout_o <= !rst_i && ext_act && !ext_ready && ext_cnt_r == 8'(EXT_LIM - 1);
   end
endmodule

// file: dmatsc_top_test.sv
// self-checking bench for the dma time-out and service sequencer
// assumes the far-side model answers peripheral and external accesses
`timescale 1ns/100ps
`include "dmatsc_defs.svh"
module dmatsc_top_test;
   logic                    clk_i = 1'b0;
   logic                    rst_i = 1'b1;
   logic                    cyc_i = 1'b0;
   logic                    stb_i = 1'b0;
   logic                    we_i = 1'b0;
   logic [7:0]              adr_i = 8'h00;
   logic [3:0]              sel_i = 4'h0;
   logic [31:0]             dat_i = 32'h0;
   logic [31:0]             dat_o;
   logic                    ack_o;
   logic [5:0]              sync_evt_i = 6'h00;
   logic [5:0]              src_port_peri_i = 6'h00;
   logic [5:0]              src_ram_dual_i = 6'h3f;
   logic [5:0]              dst_ram_dual_i = 6'h3f;
   logic [5:0]              last_elem_i = 6'h00;
   logic                    cpu_sram_req_i = 1'b0;
   logic [1:0]              cpu_dram_cnt_i = 2'h2;
   logic                    host_req_i = 1'b0;
   logic                    idle_req_i = 1'b0;
   logic                    serial_req_i = 1'b0;
   logic                    breakpoint_i = 1'b0;
   logic                    hang = 1'b0;
   logic                    ext_grant_i;
   logic                    ext_timeout_i;
   logic                    peri_grant_i;
   logic                    peri_timeout_i;
   dmatsc_pkg::dmatsc_acc_t acc_o;
   logic [2:0]              acc_ch_o;
   logic                    host_slot_o;
   logic                    idle_o;
   logic                    bus_err_irq_o;
   logic [31:0]             q;
   logic [7:0]              seen;
   int                      err_count = 0;
   int                      cmp_count = 0;
   int                      n;
   int                      nrd;
   int                      nwr;
   dmatsc_top #(.NCH(6)) dmatsc_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .sync_evt_i(sync_evt_i), .src_port_peri_i(src_port_peri_i),
      .src_ram_dual_i(src_ram_dual_i), .dst_ram_dual_i(dst_ram_dual_i),
      .last_elem_i(last_elem_i), .cpu_sram_req_i(cpu_sram_req_i),
      .cpu_dram_cnt_i(cpu_dram_cnt_i), .ext_grant_i(ext_grant_i),
      .ext_timeout_i(ext_timeout_i), .peri_grant_i(peri_grant_i),
      .peri_timeout_i(peri_timeout_i), .host_req_i(host_req_i), .idle_req_i(idle_req_i),
      .serial_req_i(serial_req_i), .breakpoint_i(breakpoint_i), .acc_o(acc_o),
      .acc_ch_o(acc_ch_o), .host_slot_o(host_slot_o), .idle_o(idle_o),
      .bus_err_irq_o(bus_err_irq_o));
   dmatsc_far_model dmatsc_far_model_i (.clk_i(clk_i), .rst_i(rst_i), .acc_i(acc_o),
      .hang_i(hang), .peri_grant_o(peri_grant_i), .peri_timeout_o(peri_timeout_i),
      .ext_grant_o(ext_grant_i), .ext_timeout_o(ext_timeout_i));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   function automatic logic [7:0] ca(input logic [2:0] ch, input logic [3:0] ofs);
      return `DMATSC_CH_BASE + `DMATSC_CH_STRIDE * ch + {4'h0, ofs};
   endfunction
   task automatic check(input string nm, input logic [31:0] sn, input logic [31:0] ex);
      cmp_count++;
      if (sn !== ex) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, ex, sn);
      end
   endtask
   // request held until the edge that samples ack; released only after it
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 50);
      check("wb ack", {31'h0, ack_o}, 32'h1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      check(nm, q, e);
   endtask
   task automatic cnt_req(input int c);
      n = 0;
      repeat (c) begin
         @(posedge clk_i);
         if (acc_o.req === 1'b1) n++;
      end
   endtask
   // quiet for lo cycles, then the bus error within hi
   task automatic wait_irq(input int lo, input int hi);
      repeat (lo) @(posedge clk_i);
      check("irq early", {31'h0, bus_err_irq_o}, 32'h0);
      n = lo;
      while (bus_err_irq_o !== 1'b1 && n < hi) begin
         @(posedge clk_i);
         n++;
      end
      check("irq late", {31'h0, bus_err_irq_o}, 32'h1);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #80000;
      err_count++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd("gcr", `DMATSC_GCR_ADDR, 32'h8);
      rd("gscr", `DMATSC_GSCR_ADDR, 32'h0);
      rd("gtcr", `DMATSC_GTCR_ADDR, 32'h0);
      rd("ccr0", ca(0, `DMATSC_CCR_OFS), 32'h0);
      rd("unmapped", 8'hfc, 32'h0);
      wb(1'b1, `DMATSC_GTCR_ADDR, 32'h3);
      rd("gtcr wr", `DMATSC_GTCR_ADDR, 32'h3);
      wb(1'b1, `DMATSC_GSCR_ADDR, 32'h1);
      rd("gscr wr", `DMATSC_GSCR_ADDR, 32'h1);
      // two dual-ram channels plus host sharing, cpu at two accesses
      host_req_i <= 1'b1;
      for (int c = 0; c < 3; c++) wb(1'b1, ca(c[2:0], `DMATSC_CICR_OFS), 32'h1);
      wb(1'b1, ca(0, `DMATSC_CCR_OFS), 32'h80);
      wb(1'b1, ca(1, `DMATSC_CCR_OFS), 32'h80);
      nrd = 0;
      nwr = 0;
      seen = 8'h00;
      repeat (300) begin
         @(posedge clk_i);
         if (acc_o.req === 1'b1 && acc_o.wr === 1'b1) nwr++;
         if (acc_o.req === 1'b1 && acc_o.wr === 1'b0) nrd++;
         if (acc_o.req === 1'b1) seen[acc_ch_o] = 1'b1;
      end
      host_req_i <= 1'b0;
      check("rd before wr", 32'(nwr <= nrd && nrd <= nwr + 2), 32'h1);
      check("rate", 32'(nrd + nwr >= 100), 32'h1);
      check("both served", {24'h0, seen}, 32'h3);
      check("no timeout", {31'h0, bus_err_irq_o}, 32'h0);
      breakpoint_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      cnt_req(10);
      check("bp stops", n, 0);
      wb(1'b1, `DMATSC_GCR_ADDR, 32'hc);
      cnt_req(10);
      check("free runs", 32'(n > 0), 32'h1);
      breakpoint_i <= 1'b0;
      wb(1'b1, `DMATSC_GCR_ADDR, 32'ha);
      repeat (3) @(posedge clk_i);
      cnt_req(10);
      check("excl blocks", n, 0);
      check("host slot", {31'h0, host_slot_o}, 32'h1);
      wb(1'b1, `DMATSC_GCR_ADDR, 32'h8);
      wb(1'b1, ca(1, `DMATSC_CCR_OFS), 32'h0);
      // let an element already begun on channel 1 finish unstalled
      repeat (4) @(posedge clk_i);
      cpu_dram_cnt_i <= 2'h3;
      wait_irq(240, 275);
      rd("ccr0 off", ca(0, `DMATSC_CCR_OFS), 32'h0);
      rd("csr0 set", ca(0, `DMATSC_CSR_OFS), 32'h1);
      rd("csr0 clr", ca(0, `DMATSC_CSR_OFS), 32'h0);
      // single ram stalled by the cpu
      cpu_dram_cnt_i <= 2'h0;
      src_ram_dual_i <= 6'h00;
      dst_ram_dual_i <= 6'h00;
      cpu_sram_req_i <= 1'b1;
      wb(1'b1, ca(0, `DMATSC_CCR_OFS), 32'h80);
      wait_irq(240, 275);
      rd("csr0 sram", ca(0, `DMATSC_CSR_OFS), 32'h1);
      wb(1'b1, ca(1, `DMATSC_CICR_OFS), 32'h0);
      wb(1'b1, ca(1, `DMATSC_CCR_OFS), 32'h80);
      repeat (300) @(posedge clk_i);
      check("no ie irq", {31'h0, bus_err_irq_o}, 32'h0);
      rd("ccr1 off", ca(1, `DMATSC_CCR_OFS), 32'h0);
      rd("csr1 clear", ca(1, `DMATSC_CSR_OFS), 32'h0);
      cpu_sram_req_i <= 1'b0;
      // peripheral source that never answers
      src_port_peri_i <= 6'h04;
      hang <= 1'b1;
      wb(1'b1, ca(2, `DMATSC_CCR_OFS), 32'h80);
      wait_irq(110, 145);
      rd("csr2 set", ca(2, `DMATSC_CSR_OFS), 32'h1);
      hang <= 1'b0;
      src_port_peri_i <= 6'h00;
      src_ram_dual_i <= 6'h3f;
      dst_ram_dual_i <= 6'h3f;
      wb(1'b1, ca(3, `DMATSC_CCR_OFS), 32'h81);
      cnt_req(30);
      check("sync wait", n, 0);
      sync_evt_i <= 6'h08;
      @(posedge clk_i);
      sync_evt_i <= 6'h00;
      cnt_req(30);
      check("sync go", 32'(n > 0), 32'h1);
      wb(1'b1, ca(3, `DMATSC_CCR_OFS), 32'h0);
      // idle request in mid block: the block runs on to its last element
      wb(1'b1, ca(0, `DMATSC_CCR_OFS), 32'h80);
      repeat (6) @(posedge clk_i);
      idle_req_i <= 1'b1;
      cnt_req(20);
      check("block runs", 32'(n > 0), 32'h1);
      check("not idle yet", {31'h0, idle_o}, 32'h0);
      last_elem_i <= 6'h3f;
      n = 0;
      while (idle_o !== 1'b1 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      check("idle", {31'h0, idle_o}, 32'h1);
      serial_req_i <= 1'b1;
      @(posedge clk_i);
      serial_req_i <= 1'b0;
      cnt_req(10);
      check("serial wake", 32'(n > 0), 32'h1);
      check("idle kept", {31'h0, idle_o}, 32'h1);
      report_and_stop();
   end
endmodule
